//--- inc/exri_cfg.svh
// constants for the exception-return and interrupt-masking unit
// assumes byte offsets on a plain register port with 8-bit address
`ifndef EXRI_CFG_SVH
`define EXRI_CFG_SVH

// ************************************************************
// register offsets
// ************************************************************
`define EXRI_OFS_STATUS 8'h00
`define EXRI_OFS_ESTATUS 8'h04
`define EXRI_OFS_SSTATUS 8'h08
`define EXRI_OFS_CONFIG 8'h0C
`define EXRI_OFS_IRQ_MASK 8'h10
`define EXRI_OFS_IRQ_PEND 8'h14
`define EXRI_OFS_RET_ADDR 8'h18
`define EXRI_OFS_EVT_STAT 8'h1C
`define EXRI_OFS_EVT_MASK 8'h20

// ************************************************************
// field positions and widths
// ************************************************************
`define EXRI_CFG_ANI_BIT 0
`define EXRI_CFG_EIC_BIT 1
`define EXRI_EVT_IRQ_BIT 0
`define EXRI_EVT_NMI_BIT 1
`define EXRI_EVT_EXC_BIT 2
`define EXRI_EVT_RET_BIT 3
`define EXRI_EVT_W 4
`define EXRI_SET_W 2
`define EXRI_NUM_SETS 4
`define EXRI_LVL_W 6

// ************************************************************
// reset values and masks
// ************************************************************
`define EXRI_STATUS_WMASK 32'h00C30FF1
`define EXRI_STATUS_RST 32'h00000000
`define EXRI_CONFIG_RST 2'h0
`define EXRI_MASK_RST 32'h00000000
`define EXRI_PC_STEP 32'h00000004

`endif

//--- inc/exri_pkg.sv
// types for the exception-return and interrupt-masking unit
// assumes exri_cfg.svh is on the include path
`include "exri_cfg.svh"

package exri_pkg;

  // ************************************************************
  // processor status word
  // ************************************************************
  typedef struct packed {
    logic [7:0] rsv_hi;
    logic same_set_preempt_enable;
    logic nmi_mode;
    logic [3:0] rsv_mid;
    logic [`EXRI_SET_W-1:0] previous_set;
    logic [3:0] rsv_lo;
    logic [`EXRI_SET_W-1:0] current_shadow_set;
    logic [`EXRI_LVL_W-1:0] interrupt_level_threshold;
    logic [2:0] rsv_bot;
    logic global_irq_enable;
  } exri_status_t;

  // ************************************************************
  // request from the external interrupt controller
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic nmi;
    logic [`EXRI_LVL_W-1:0] level;
    logic [`EXRI_SET_W-1:0] reg_set;
  } exri_eic_req_t;

  // ************************************************************
  // register port request
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } exri_reg_req_t;

endpackage : exri_pkg

//--- core/exri_core.sv
// exception-return and interrupt-masking unit of a processor core
// assumes the core pulses exc_req / eret_req for one cycle, presents
// the current instruction address on exc_pc, and reacts to the
// take pulses and the return redirect in the cycle after
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`include "exri_cfg.svh"

module exri_core
  import exri_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire exri_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire logic exc_req,
  input wire logic [31:0] exc_pc,
  input wire logic eret_req,
  input wire logic [31:0] irq_lines,
  input wire exri_eic_req_t eic_req,
  output logic irq_take,
  output logic nmi_take,
  output logic ret_valid,
  output logic [31:0] ret_pc,
  output logic [`EXRI_SET_W-1:0] active_set,
  output exri_status_t status_out,
  output logic irq_out
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // clear reserved bits of a status value
  function automatic exri_status_t clean_status(input logic [31:0] v);
    clean_status = exri_status_t'(v & `EXRI_STATUS_WMASK);
  endfunction : clean_status

  // register port address match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ************************************************************
  // state
  // ************************************************************
  exri_status_t status_ff;
  exri_status_t estatus_ff;
  exri_status_t sstatus_ff;
  logic [1:0] config_ff;
  logic [31:0] irq_line_mask_ff;
  logic [31:0] ret_addr_ff [`EXRI_NUM_SETS];
  logic [`EXRI_EVT_W-1:0] evt_stat_ff;
  logic [`EXRI_EVT_W-1:0] evt_mask_ff;
  logic [31:0] rdata_ff;
  logic ret_valid_ff;
  logic [31:0] ret_pc_ff;

  // ************************************************************
  // decoded controls
  // ************************************************************
  logic auto_nesting_enable;
  logic eic_mode;
  logic [31:0] irq_pend;
  logic same_set_block;
  logic irq_ok;
  logic nmi_ok;
  logic take_any;
  logic do_eret;
  logic [`EXRI_SET_W-1:0] new_set;
  exri_status_t restored;
  exri_status_t taken_status;
  logic wr_status;
  logic wr_ret_addr;
  logic [`EXRI_EVT_W-1:0] evt_set;
  logic [`EXRI_EVT_W-1:0] evt_clr;

  assign auto_nesting_enable = config_ff[`EXRI_CFG_ANI_BIT];
  assign eic_mode = config_ff[`EXRI_CFG_EIC_BIT];

  // per-line enable of the internal controller
  assign irq_pend = irq_lines & irq_line_mask_ff;

  // a handler running in a shadow set blocks its own set unless same_set_preempt_enable is set
  assign same_set_block = !status_ff.same_set_preempt_enable &&
    (status_ff.current_shadow_set != '0) &&
    (eic_req.reg_set == status_ff.current_shadow_set);

  // ************************************************************
  // interrupt acceptance
  // ************************************************************

  // an instruction exception always wins over an interrupt
  always_comb
  begin
    irq_ok = 1'b0;
    nmi_ok = 1'b0;
    if (eic_mode)
    begin
      // nmi ignores enable and threshold, never nests
      nmi_ok = eic_req.valid && eic_req.nmi && !status_ff.nmi_mode;
      irq_ok = eic_req.valid && !eic_req.nmi &&
        status_ff.global_irq_enable &&
        !status_ff.nmi_mode &&
        (eic_req.level >
         status_ff.interrupt_level_threshold) &&
        !same_set_block;
    end
    else
    begin
      irq_ok = status_ff.global_irq_enable &&
        (irq_pend != 32'h00000000) && !status_ff.nmi_mode;
    end
    if (exc_req)
    begin
      irq_ok = 1'b0;
      nmi_ok = 1'b0;
    end
  end

  assign take_any = exc_req || irq_ok || nmi_ok;
  assign do_eret = eret_req && !take_any;

  // register set of the handler being entered
  assign new_set = (eic_mode && (irq_ok || nmi_ok)) ?
    eic_req.reg_set : '0;

  // ************************************************************
  // status values for return and entry
  // ************************************************************

  // pick the saved copy by the current set and guard nmi mode
  always_comb
  begin
    if (status_ff.current_shadow_set == '0)
    begin
      restored = estatus_ff;
    end
    else
    begin
      restored = sstatus_ff;
    end
    // may leave nmi mode, never enter it
    restored.nmi_mode = restored.nmi_mode &&
      status_ff.nmi_mode;
    restored = clean_status(restored);
  end

  // status after entering a handler
  always_comb
  begin
    taken_status = status_ff;
    taken_status.previous_set = status_ff.current_shadow_set;
    taken_status.current_shadow_set = new_set;
    if (nmi_ok)
    begin
      taken_status.nmi_mode = 1'b1;
    end
    if (eic_mode && irq_ok)
    begin
      taken_status.interrupt_level_threshold = eic_req.level;
    end
    // nmi and exceptions always disable, irq unless nesting
    if (exc_req || nmi_ok || (irq_ok && !auto_nesting_enable))
    begin
      taken_status.global_irq_enable = 1'b0;
    end
  end

  // ************************************************************
  // register port decode
  // ************************************************************
  assign wr_status = reg_req.wr && hit(reg_req.addr, `EXRI_OFS_STATUS);
  assign wr_ret_addr = reg_req.wr &&
    hit(reg_req.addr, `EXRI_OFS_RET_ADDR);
  assign evt_clr = (reg_req.wr && hit(reg_req.addr, `EXRI_OFS_EVT_STAT)) ?
    reg_req.wdata[`EXRI_EVT_W-1:0] : '0;

  // ************************************************************
  // status register
  // ************************************************************

  // hardware entry or return beats a software write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_ff <= exri_status_t'(`EXRI_STATUS_RST);
    end
    else if (take_any)
    begin
      status_ff <= taken_status;
    end
    else if (do_eret)
    begin
      status_ff <= restored;
    end
    else if (wr_status)
    begin
      status_ff <= clean_status(reg_req.wdata);
    end
  end

  // ************************************************************
  // saved status copies
  // ************************************************************

  // entry into set zero saves normal copy, shadow set the other
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      estatus_ff <= exri_status_t'(`EXRI_STATUS_RST);
    end
    else if (take_any && (new_set == '0))
    begin
      estatus_ff <= status_ff;
    end
    else if (reg_req.wr && hit(reg_req.addr, `EXRI_OFS_ESTATUS))
    begin
      estatus_ff <= clean_status(reg_req.wdata);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sstatus_ff <= exri_status_t'(`EXRI_STATUS_RST);
    end
    else if (take_any && (new_set != '0))
    begin
      sstatus_ff <= status_ff;
    end
    else if (reg_req.wr && hit(reg_req.addr, `EXRI_OFS_SSTATUS))
    begin
      sstatus_ff <= clean_status(reg_req.wdata);
    end
  end

  // ************************************************************
  // return address per register set
  // ************************************************************

  // entry stores the address after the instruction on exc_pc
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `EXRI_NUM_SETS; i++)
      begin
        ret_addr_ff[i] <= 32'h00000000;
      end
    end
    else if (take_any)
    begin
      ret_addr_ff[new_set] <= exc_pc + `EXRI_PC_STEP;
    end
    else if (wr_ret_addr)
    begin
      // handler adjusts the address in its own set
      ret_addr_ff[status_ff.current_shadow_set] <=
        reg_req.wdata;
    end
  end

  // ************************************************************
  // return redirect
  // ************************************************************

  // target taken from the set active before the return
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ret_valid_ff <= 1'b0;
      ret_pc_ff <= 32'h00000000;
    end
    else
    begin
      ret_valid_ff <= do_eret;
      if (do_eret)
      begin
        ret_pc_ff <= ret_addr_ff[status_ff.current_shadow_set];
      end
    end
  end

  // ************************************************************
  // configuration and line mask
  // ************************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      config_ff <= `EXRI_CONFIG_RST;
    end
    else if (reg_req.wr && hit(reg_req.addr, `EXRI_OFS_CONFIG))
    begin
      config_ff <= reg_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_line_mask_ff <= `EXRI_MASK_RST;
    end
    else if (reg_req.wr && hit(reg_req.addr, `EXRI_OFS_IRQ_MASK))
    begin
      irq_line_mask_ff <= reg_req.wdata;
    end
  end

  // ************************************************************
  // event status and mask
  // ************************************************************
  always_comb
  begin
    evt_set = '0;
    evt_set[`EXRI_EVT_IRQ_BIT] = irq_ok;
    evt_set[`EXRI_EVT_NMI_BIT] = nmi_ok;
    evt_set[`EXRI_EVT_EXC_BIT] = exc_req;
    evt_set[`EXRI_EVT_RET_BIT] = do_eret;
  end

  // write one to clear, a new event wins over the clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      evt_stat_ff <= '0;
    end
    else
    begin
      evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      evt_mask_ff <= '0;
    end
    else if (reg_req.wr && hit(reg_req.addr, `EXRI_OFS_EVT_MASK))
    begin
      evt_mask_ff <= reg_req.wdata[`EXRI_EVT_W-1:0];
    end
  end

  // ************************************************************
  // read data, one cycle after the strobe
  // ************************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_ff <= 32'h00000000;
    end
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        `EXRI_OFS_STATUS: rdata_ff <= status_ff;
        `EXRI_OFS_ESTATUS: rdata_ff <= estatus_ff;
        `EXRI_OFS_SSTATUS: rdata_ff <= sstatus_ff;
        `EXRI_OFS_CONFIG: rdata_ff <= {30'h00000000, config_ff};
        `EXRI_OFS_IRQ_MASK: rdata_ff <= irq_line_mask_ff;
        `EXRI_OFS_IRQ_PEND: rdata_ff <= irq_pend;
        `EXRI_OFS_RET_ADDR:
          rdata_ff <= ret_addr_ff[status_ff.current_shadow_set];
        `EXRI_OFS_EVT_STAT: rdata_ff <= {28'h0000000, evt_stat_ff};
        `EXRI_OFS_EVT_MASK: rdata_ff <= {28'h0000000, evt_mask_ff};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
    else
    begin
      rdata_ff <= 32'h00000000;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata = rdata_ff;
  assign irq_take = irq_ok; // combinational handshake
  assign nmi_take = nmi_ok; // combinational handshake
  assign ret_valid = ret_valid_ff;
  assign ret_pc = ret_pc_ff;
  assign active_set = status_ff.current_shadow_set;
  assign status_out = status_ff;
  assign irq_out = |(evt_stat_ff & evt_mask_ff);

endmodule : exri_core

//--- tb/exri_irq_src.sv
// interrupt source model: request lines and an external controller
// assumes the bench posts requests after a rising edge
module exri_irq_src
  import exri_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [31:0] line_cmd,
  input wire exri_eic_req_t eic_cmd,
  input wire logic post,
  input wire logic irq_take,
  input wire logic nmi_take,
  output exri_eic_req_t eic_req,
  output logic [31:0] irq_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines are levels, held until the bench drops them
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_lines <= '0;
    else
      irq_lines <= line_cmd;
  end
  // request held until taken, then withdrawn with scrambled fields
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      eic_req <= '0;
    else if (post)
      eic_req <= eic_cmd;
    else if (irq_take || nmi_take)
      eic_req <= {1'b0, ~eic_req[8:0]};
  end
endmodule : exri_irq_src

//--- tb/exri_checker.sv
// port checker for the exception-return unit
// assumes it is bound to exri_core
module exri_checker
  import exri_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic exc_req,
  input wire logic eret_req,
  input wire logic [31:0] irq_lines,
  input wire exri_eic_req_t eic_req,
  input wire logic irq_take,
  input wire logic nmi_take,
  input wire logic ret_valid,
  input wire logic [1:0] active_set,
  input wire exri_status_t status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ret_after_eret:
    assert property (ret_valid |-> $past(eret_req))
    else $error("redirect without return");
  a_ret_on_eret:
    assert property (eret_req && !exc_req && !irq_take && !nmi_take
      |=> ret_valid)
    else $error("return not redirected");
  a_no_nmi_entry:
    assert property (ret_valid && !$past(status_out.nmi_mode)
      |-> !status_out.nmi_mode)
    else $error("return entered nmi mode");
  a_enable_gates:
    assert property (!status_out.global_irq_enable |-> !irq_take)
    else $error("irq taken while disabled");
  a_level_gate:
    assert property (irq_take |-> (|irq_lines) || (eic_req.valid &&
      !eic_req.nmi && eic_req.level >
      status_out.interrupt_level_threshold))
    else $error("irq taken at or below threshold");
  a_exc_to_set0:
    assert property (exc_req |=> active_set == 2'h0 &&
      !status_out.global_irq_enable)
    else $error("exception state wrong");
  a_nmi_clears:
    assert property (nmi_take && !exc_req
      |=> !status_out.global_irq_enable && status_out.nmi_mode)
    else $error("nmi left irqs enabled");
  a_entry_saves_set:
    assert property (exc_req || irq_take || nmi_take
      |=> status_out.previous_set == $past(active_set))
    else $error("entry lost the interrupted set");
endmodule : exri_checker

//--- tb/exri_core_bench.sv
// self-checking bench for the exception-return unit
// assumes exri_core, exri_irq_src and exri_checker
`include "exri_cfg.svh"
module exri_core_bench
  import exri_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  exri_reg_req_t req = '0;
  logic exc_req = 1'b0;
  logic eret_req = 1'b0;
  logic post = 1'b0;
  logic [31:0] exc_pc = 32'h0;
  logic [31:0] line_cmd = 32'h0;
  exri_eic_req_t eic_cmd = '0;
  exri_eic_req_t external_irq_controller;
  exri_status_t status;
  logic [31:0] rdata, lines, ret_pc;
  logic [1:0] aset;
  logic irq_take, nmi_take, ret_valid, irq_out;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  exri_core i_exri_core (.clk(clk), .resetn(resetn), .reg_req(req),
    .reg_rdata(rdata), .exc_req(exc_req), .exc_pc(exc_pc),
    .eret_req(eret_req), .irq_lines(lines), .eic_req(external_irq_controller),
    .irq_take(irq_take), .nmi_take(nmi_take), .ret_valid(ret_valid),
    .ret_pc(ret_pc), .active_set(aset), .status_out(status),
    .irq_out(irq_out));
  exri_irq_src i_exri_irq_src (.clk(clk), .resetn(resetn),
    .line_cmd(line_cmd), .eic_cmd(eic_cmd), .post(post),
    .irq_take(irq_take), .nmi_take(nmi_take), .eic_req(external_irq_controller),
    .irq_lines(lines));
  // ****************
  // helpers
  // ****************
  task conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd
  // one-cycle exception or return pulse
  task go(input logic ret);
    @(posedge clk);
    if (ret)
      eret_req <= 1'b1;
    else
      exc_req <= 1'b1;
    @(posedge clk);
    eret_req <= 1'b0;
    exc_req <= 1'b0;
    @(negedge clk);
  endtask : go
  task send(input exri_eic_req_t r);
    @(posedge clk);
    eic_cmd <= r;
    post <= 1'b1;
    @(posedge clk);
    post <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : send
  task lines_to(input logic [31:0] v);
    @(posedge clk);
    line_cmd <= v;
    repeat (4) @(posedge clk);
  endtask : lines_to
  // ****************
  // scenarios
  // ****************
  task t_regs;
    rd(`EXRI_OFS_STATUS, 32'h0);
    wr(`EXRI_OFS_IRQ_MASK, 32'hA5A5F00F);
    rd(`EXRI_OFS_IRQ_MASK, 32'hA5A5F00F);
    rd(8'h3C, 32'h0);
  endtask : t_regs
  task t_lines;
    wr(`EXRI_OFS_IRQ_MASK, 32'h8);
    lines_to(32'h28);
    rd(`EXRI_OFS_EVT_STAT, 32'h0);
    rd(`EXRI_OFS_IRQ_PEND, 32'h8);
    lines_to(32'h20);
    wr(`EXRI_OFS_STATUS, 32'h1);
    repeat (4) @(posedge clk);
    rd(`EXRI_OFS_EVT_STAT, 32'h0);
    lines_to(32'h28);
    rd(`EXRI_OFS_EVT_STAT, 32'h1);
    chk(status.global_irq_enable, 32'h0);
    wr(`EXRI_OFS_EVT_MASK, 32'h1);
    @(negedge clk);
    chk(irq_out, 32'h1);
    wr(`EXRI_OFS_EVT_STAT, 32'h1);
    @(negedge clk);
    chk(irq_out, 32'h0);
    lines_to(32'h0);
  endtask : t_lines
  task t_exc;
    wr(`EXRI_OFS_STATUS, 32'h1);
    exc_pc <= 32'h100;
    go(1'b0);
    chk(status, 32'h0);
    rd(`EXRI_OFS_RET_ADDR, 32'h104);
    rd(`EXRI_OFS_ESTATUS, 32'h1);
    wr(`EXRI_OFS_ESTATUS, 32'h00400011);
    wr(`EXRI_OFS_RET_ADDR, 32'h104 - 32'h4);
    go(1'b1);
    chk(ret_valid, 32'h1);
    chk(ret_pc, 32'h100);
    chk(status, 32'h11);
  endtask : t_exc
  task t_eic;
    wr(`EXRI_OFS_CONFIG, 32'h3);
    wr(`EXRI_OFS_STATUS, 32'h3F1);
    exc_pc <= 32'h200;
    send('{1'b1, 1'b0, 6'h3F, 2'h2});
    chk(irq_take, 32'h0);
    chk(status, 32'h3F1);
    send('{1'b1, 1'b0, 6'h01, 2'h2});
    wr(`EXRI_OFS_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(status, 32'h811);
    chk(aset, 32'h2);
    send('{1'b1, 1'b0, 6'h01, 2'h3});
    chk(irq_take, 32'h0);
    chk(status, 32'h811);
    send('{1'b1, 1'b0, 6'h05, 2'h2});
    chk(irq_take, 32'h0);
    chk(status, 32'h811);
    send('0);
    go(1'b1);
    chk(ret_pc, 32'h204);
    chk(status, 32'h1);
    chk(aset, 32'h0);
    send('{1'b1, 1'b1, 6'h00, 2'h0});
    chk(status.nmi_mode, 32'h1);
    go(1'b1);
    chk(status, 32'h1);
  endtask : t_eic
  // ****************
  // sequence and watchdog
  // ****************
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_lines;
    t_exc;
    t_eic;
    conclude;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      conclude;
    end
  end
endmodule : exri_core_bench

bind exri_core exri_checker i_exri_checker (.clk(clk), .resetn(resetn),
  .exc_req(exc_req), .eret_req(eret_req), .irq_lines(irq_lines),
  .eic_req(eic_req), .irq_take(irq_take), .nmi_take(nmi_take),
  .ret_valid(ret_valid), .active_set(active_set),
  .status_out(status_out));
